// ===== verilog/ccc_consts.svh
// Constants for the L1 cache coherency controller.
`ifndef CCC_CONSTS_SVH
`define CCC_CONSTS_SVH
`define CCC_PAGE_FLUSH_INVALIDATE_ADDR   32'hc0000088
`define CCC_SETS        16
`define CCC_LAST_SET    4'hf
`define CCC_IDX_W       4
`define CCC_TAG_W       23
`define CCC_IDX_LSB     5
`define CCC_TAG_LSB     9
`define CCC_PG_TAG_LSB  3
`define CCC_LP_MSB      31
`define CCC_LP_LSB      12
`define CCC_PF_BIT      0
`define CCC_FI_BIT      1
`define CCC_LINE_LEN    6'h20
`define CCC_KEN_WAIT    3'h4
`define CCC_PIN_RST     32'ha8000000
`endif

// ===== verilog/ccc_pkg.sv
// Types shared by the L1 cache coherency controller.
package ccc_pkg;
  typedef enum logic [1:0] {MESI_I, MESI_S, MESI_E, MESI_M} ccc_mesi_e;
  typedef enum logic [1:0] {BUS_SRD, BUS_SWR, BUS_BRD, BUS_BWR} ccc_kind_e;
  typedef enum logic [2:0] {ST_IDLE, ST_DMISS, ST_WB, ST_FILL, ST_SRD, ST_SWR, ST_SCAN} ccc_state_e;
  typedef struct packed {
    logic        wr;
    logic        icache;
    logic [31:0] addr;
    logic [3:0]  bytes;
    logic        page_write_through;
    logic        walloc;
  } ccc_req_s;
  typedef struct packed {
    ccc_kind_e   kind;
    logic [31:0] addr;
    logic [5:0]  len;
  } ccc_bus_s;
endpackage : ccc_pkg

// ===== verilog/ccc_sync.sv
// Two-flop synchroniser for processor bus pins.
`timescale 1ns/1ps
module ccc_sync #(
  parameter int          W   = 32,
  parameter logic [31:0] RST = 32'h0
) (
  input  wire logic         clk_in,
  input  wire logic         reset_n_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      meta_q <= RST[W-1:0];
      q_out  <= RST[W-1:0];
    end else begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end
endmodule : ccc_sync

// ===== verilog/ccc_coherency_ctrl.sv
// MESI coherency controller for the L1 instruction and data caches.
`timescale 1ns/1ps
`include "ccc_consts.svh"
module ccc_coherency_ctrl import ccc_pkg::*; (
  // Clock and reset
  input  wire logic        CLK_IN,
  input  wire logic        RESET_N_IN,
  // Core access port
  input  wire logic        CORE_VALID_IN,
  input  wire ccc_req_s    CORE_REQ_IN,
  output logic             CORE_ACK_OUT,
  output logic             CORE_HIT_OUT,
  // Bus cycle port
  output logic             BUS_REQ_OUT,
  output ccc_bus_s         BUS_CMD_OUT,
  input  wire logic        BUS_DONE_IN,
  output logic             LINE_FILL_REQUEST_N_OUT,
  // Processor bus pins
  input  wire logic        CACHE_ENABLE_N_IN,
  input  wire logic        WRITEBACK_SELECT_IN,
  input  wire logic        EXTERNAL_ADDRESS_STROBE_N_IN,
  input  wire logic        INVALIDATE_REQUEST_IN,
  input  wire logic        CACHE_FLUSH_N_IN,
  input  wire logic [31:5] INQUIRE_ADDR_IN,
  output logic             INQUIRE_HIT_N_OUT,
  output logic             INQUIRE_HIT_MODIFIED_N_OUT,
  // Model register port
  input  wire logic        MODEL_REG_WRITE_IN,
  input  wire logic        MODEL_REG_READ_IN,
  input  wire logic [31:0] MODEL_REG_ADDR_IN,
  input  wire logic [63:0] MODEL_REG_WDATA_IN,
  input  wire logic        PAGE_FAULT_IN,
  output logic      [63:0] MODEL_REG_RDATA_OUT
);
  typedef logic [`CCC_TAG_W-1:0] ccc_tag_t;
  typedef logic [`CCC_IDX_W-1:0] ccc_idx_t;

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  function automatic ccc_idx_t idx_of(input logic [31:0] a);
    return a[`CCC_TAG_LSB-1:`CCC_IDX_LSB];
  endfunction : idx_of

  function automatic ccc_tag_t tag_of(input logic [31:0] a);
    return a[31:`CCC_TAG_LSB];
  endfunction : tag_of

  function automatic ccc_bus_s mk_bus(input ccc_kind_e k, input logic [31:0] a, input logic [5:0] n);
    ccc_bus_s b;
    b.kind = k;
    b.addr = a;
    b.len  = n;
    return b;
  endfunction : mk_bus

  function automatic logic [31:0] line_of(input ccc_tag_t t, input ccc_idx_t i);
    return {t, i, 5'h00};
  endfunction : line_of

  // ****************************************************************
  // Pin synchronisation and event capture
  // ****************************************************************
  logic [31:0] pins_s;
  logic        ken_n_s, wbsel_s, external_address_strobe_n_s, inv_s, flush_n_s;
  logic [31:5] iaddr_s;
  logic        external_address_strobe_prev_q, flush_prev_q;
  logic        inq_pend_q, flush_pend_q, page_pend_q, inq_inv_q;
  logic [31:5] inq_addr_q;
  logic [`CCC_LP_MSB:`CCC_LP_LSB] linear_page_number_q;
  logic        fi_q, pf_q;
  logic        take_inq, take_flush, take_page, take_core, page_flush_invalidate_wr;

  ccc_sync #(.W(32), .RST(`CCC_PIN_RST)) u_sync (
    .clk_in     (CLK_IN),
    .reset_n_in (RESET_N_IN),
    .d_in       ({CACHE_ENABLE_N_IN, WRITEBACK_SELECT_IN, EXTERNAL_ADDRESS_STROBE_N_IN,
                  INVALIDATE_REQUEST_IN, CACHE_FLUSH_N_IN, INQUIRE_ADDR_IN}),
    .q_out      (pins_s)
  );
  assign {ken_n_s, wbsel_s, external_address_strobe_n_s, inv_s, flush_n_s, iaddr_s} = pins_s;

  assign page_flush_invalidate_wr = MODEL_REG_WRITE_IN && (MODEL_REG_ADDR_IN == `CCC_PAGE_FLUSH_INVALIDATE_ADDR);

  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      external_address_strobe_prev_q  <= 1'b1;
      flush_prev_q <= 1'b1;
      inq_pend_q   <= 1'b0;
      inq_inv_q    <= 1'b0;
      inq_addr_q   <= '0;
      flush_pend_q <= 1'b0;
    end else begin
      external_address_strobe_prev_q  <= external_address_strobe_n_s;
      flush_prev_q <= flush_n_s;
      if (external_address_strobe_prev_q && !external_address_strobe_n_s) begin
        inq_pend_q <= 1'b1;
        inq_addr_q <= iaddr_s;
        inq_inv_q  <= inv_s;
      end else if (take_inq) begin
        inq_pend_q <= 1'b0;
      end
      if (flush_prev_q && !flush_n_s) begin
        flush_pend_q <= 1'b1;
      end else if (take_flush) begin
        flush_pend_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Page flush/invalidate register
  // ****************************************************************
  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      linear_page_number_q           <= '0;
      fi_q                <= 1'b0;
      pf_q                <= 1'b0;
      page_pend_q         <= 1'b0;
      MODEL_REG_RDATA_OUT <= '0;
    end else begin
      if (page_flush_invalidate_wr) begin
        linear_page_number_q   <= MODEL_REG_WDATA_IN[`CCC_LP_MSB:`CCC_LP_LSB];
        fi_q        <= MODEL_REG_WDATA_IN[`CCC_FI_BIT];
        pf_q        <= PAGE_FAULT_IN;
        page_pend_q <= !PAGE_FAULT_IN;
      end else if (take_page) begin
        page_pend_q <= 1'b0;
      end
      MODEL_REG_RDATA_OUT <= '0;
      if (MODEL_REG_READ_IN && MODEL_REG_ADDR_IN == `CCC_PAGE_FLUSH_INVALIDATE_ADDR) begin
        MODEL_REG_RDATA_OUT[`CCC_LP_MSB:`CCC_LP_LSB] <= linear_page_number_q;
        MODEL_REG_RDATA_OUT[`CCC_FI_BIT]             <= fi_q;
        MODEL_REG_RDATA_OUT[`CCC_PF_BIT]             <= pf_q;
      end
    end
  end

  // ****************************************************************
  // Tag lookups
  // ****************************************************************
  ccc_tag_t   d_tag_q [`CCC_SETS];
  ccc_mesi_e  d_st_q  [`CCC_SETS];
  ccc_tag_t   i_tag_q [`CCC_SETS];
  logic       i_val_q [`CCC_SETS];
  ccc_state_e state_q, ret_q;
  ccc_req_s   req_q;
  ccc_bus_s   bus_q;
  ccc_idx_t   wb_idx_q, scan_q, c_idx, q_idx, r_idx;
  ccc_mesi_e  wb_next_q, upd_st_q;
  logic       upd_q, scan_all_q, scan_wb_q, hit_n_q, inquire_hit_modified_n_n_q, ack_q, hit_q;
  logic [2:0] wait_q;
  logic       c_dhit, c_ihit, q_dhit, q_ihit, wb_attr, s_dm, s_im, fill;

  always_comb begin
    c_idx  = idx_of(CORE_REQ_IN.addr);
    q_idx  = idx_of({inq_addr_q, 5'h00});
    r_idx  = idx_of(req_q.addr);
    c_dhit = d_st_q[c_idx] != MESI_I && d_tag_q[c_idx] == tag_of(CORE_REQ_IN.addr);
    c_ihit = i_val_q[c_idx] && i_tag_q[c_idx] == tag_of(CORE_REQ_IN.addr);
    q_dhit = d_st_q[q_idx] != MESI_I && d_tag_q[q_idx] == tag_of({inq_addr_q, 5'h00});
    q_ihit = i_val_q[q_idx] && i_tag_q[q_idx] == tag_of({inq_addr_q, 5'h00});
    wb_attr = !req_q.page_write_through && wbsel_s;
    s_dm   = scan_all_q || d_tag_q[scan_q][`CCC_TAG_W-1:`CCC_PG_TAG_LSB] == linear_page_number_q;
    s_im   = scan_all_q || i_tag_q[scan_q][`CCC_TAG_W-1:`CCC_PG_TAG_LSB] == linear_page_number_q;
    fill   = req_q.wr ? req_q.walloc : !ken_n_s;
  end

  assign take_inq   = state_q == ST_IDLE && inq_pend_q;
  assign take_flush = state_q == ST_IDLE && !inq_pend_q && flush_pend_q;
  assign take_page  = state_q == ST_IDLE && !inq_pend_q && !flush_pend_q && page_pend_q;
  assign take_core  = state_q == ST_IDLE && !inq_pend_q && !flush_pend_q && !page_pend_q && CORE_VALID_IN;

  assign BUS_REQ_OUT = state_q == ST_WB || state_q == ST_FILL || state_q == ST_SRD || state_q == ST_SWR;
  assign BUS_CMD_OUT = bus_q;
  assign LINE_FILL_REQUEST_N_OUT = !(state_q == ST_DMISS && !req_q.wr);
  assign INQUIRE_HIT_N_OUT = hit_n_q;
  assign INQUIRE_HIT_MODIFIED_N_OUT = inquire_hit_modified_n_n_q;
  assign CORE_ACK_OUT = ack_q;
  assign CORE_HIT_OUT = hit_q;

  // ****************************************************************
  // Coherency state machine
  // ****************************************************************
  task automatic start_wb(input ccc_idx_t i, input ccc_mesi_e nxt, input ccc_state_e ret);
    wb_idx_q  <= i;
    wb_next_q <= nxt;
    ret_q     <= ret;
    bus_q     <= mk_bus(BUS_BWR, line_of(d_tag_q[i], i), `CCC_LINE_LEN);
    state_q   <= ST_WB;
  endtask : start_wb

  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      for (int k = 0; k < `CCC_SETS; k++) begin
        d_tag_q[k] <= '0;
        d_st_q[k]  <= MESI_I;
        i_tag_q[k] <= '0;
        i_val_q[k] <= 1'b0;
      end
      state_q <= ST_IDLE;
      ret_q <= ST_IDLE;
      req_q <= '0;
      bus_q <= '0;
      wb_idx_q <= '0;
      scan_q <= '0;
      wb_next_q <= MESI_I;
      upd_st_q <= MESI_I;
      {upd_q, scan_all_q, scan_wb_q, ack_q, hit_q} <= '0;
      hit_n_q <= 1'b1;
      inquire_hit_modified_n_n_q <= 1'b1;
      wait_q <= '0;
    end else begin
      ack_q <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          if (take_inq) begin
            hit_n_q  <= !(q_ihit || q_dhit);
            inquire_hit_modified_n_n_q <= !(q_dhit && d_st_q[q_idx] == MESI_M);
            if (q_ihit && inq_inv_q) i_val_q[q_idx] <= 1'b0;
            if (q_dhit && d_st_q[q_idx] == MESI_M) begin
              start_wb(q_idx, inq_inv_q ? MESI_I : MESI_S, ST_IDLE);
            end else if (q_dhit) begin
              d_st_q[q_idx] <= inq_inv_q ? MESI_I : MESI_S;
            end
          end else if (take_flush || take_page) begin
            scan_q     <= '0;
            scan_all_q <= take_flush;
            scan_wb_q  <= take_flush || !fi_q;
            state_q    <= ST_SCAN;
          end else if (take_core) begin
            req_q <= CORE_REQ_IN;
            hit_q <= 1'b0;
            if (CORE_REQ_IN.icache) begin
              if (c_ihit) begin
                ack_q <= 1'b1;
                hit_q <= 1'b1;
              end else if (c_dhit && d_st_q[c_idx] == MESI_M) begin
                start_wb(c_idx, MESI_I, ST_FILL);
              end else begin
                if (c_dhit) d_st_q[c_idx] <= MESI_I;
                bus_q   <= mk_bus(BUS_BRD, line_of(tag_of(CORE_REQ_IN.addr), c_idx), `CCC_LINE_LEN);
                state_q <= ST_FILL;
              end
            end else if (c_dhit) begin
              if (!CORE_REQ_IN.wr || d_st_q[c_idx] != MESI_S) begin
                if (CORE_REQ_IN.wr) d_st_q[c_idx] <= MESI_M;
                ack_q <= 1'b1;
                hit_q <= 1'b1;
              end else begin
                upd_q    <= 1'b1;
                upd_st_q <= (!CORE_REQ_IN.page_write_through && wbsel_s) ? MESI_E : MESI_S;
                bus_q    <= mk_bus(BUS_SWR, CORE_REQ_IN.addr, {2'h0, CORE_REQ_IN.bytes});
                state_q  <= ST_SWR;
              end
            end else begin
              if (c_ihit) i_val_q[c_idx] <= 1'b0;
              upd_q   <= 1'b0;
              wait_q  <= '0;
              state_q <= ST_DMISS;
            end
          end
        end
        ST_DMISS: begin
          wait_q <= wait_q + 3'h1;
          if (req_q.wr || wait_q == `CCC_KEN_WAIT) begin
            if (!fill) begin
              bus_q   <= mk_bus(req_q.wr ? BUS_SWR : BUS_SRD, req_q.addr, {2'h0, req_q.bytes});
              state_q <= req_q.wr ? ST_SWR : ST_SRD;
            end else if (d_st_q[r_idx] == MESI_M) begin
              start_wb(r_idx, MESI_I, ST_FILL);
            end else begin
              bus_q   <= mk_bus(BUS_BRD, line_of(tag_of(req_q.addr), r_idx), `CCC_LINE_LEN);
              state_q <= ST_FILL;
            end
          end
        end
        ST_WB: begin
          if (BUS_DONE_IN) begin
            d_st_q[wb_idx_q] <= wb_next_q;
            state_q <= ret_q;
            if (ret_q == ST_FILL) begin
              bus_q <= mk_bus(BUS_BRD, line_of(tag_of(req_q.addr), r_idx), `CCC_LINE_LEN);
            end
          end
        end
        ST_FILL: begin
          if (BUS_DONE_IN) begin
            state_q <= ST_IDLE;
            ack_q   <= 1'b1;
            if (req_q.icache) begin
              i_tag_q[r_idx] <= tag_of(req_q.addr);
              i_val_q[r_idx] <= 1'b1;
            end else begin
              d_tag_q[r_idx] <= tag_of(req_q.addr);
              if (!req_q.wr) begin
                d_st_q[r_idx] <= wb_attr ? MESI_E : MESI_S;
              end else if (wb_attr) begin
                d_st_q[r_idx] <= MESI_M;
              end else begin
                d_st_q[r_idx] <= MESI_S;
                ack_q   <= 1'b0;
                bus_q   <= mk_bus(BUS_SWR, req_q.addr, {2'h0, req_q.bytes});
                state_q <= ST_SWR;
              end
            end
          end
        end
        ST_SRD: begin
          if (BUS_DONE_IN) begin
            ack_q   <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        ST_SWR: begin
          if (BUS_DONE_IN) begin
            if (upd_q) d_st_q[r_idx] <= upd_st_q;
            ack_q   <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        ST_SCAN: begin
          if (s_dm && scan_wb_q && d_st_q[scan_q] == MESI_M) begin
            start_wb(scan_q, MESI_I, ST_SCAN);
          end else begin
            if (s_dm) d_st_q[scan_q] <= MESI_I;
            if (s_im) i_val_q[scan_q] <= 1'b0;
            scan_q <= scan_q + 4'h1;
            if (scan_q == `CCC_LAST_SET) state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_fill_len;
    @(posedge CLK_IN) disable iff (!RESET_N_IN)
      BUS_REQ_OUT && BUS_CMD_OUT.kind inside {BUS_BRD, BUS_BWR} |-> BUS_CMD_OUT.len == `CCC_LINE_LEN;
  endproperty
  a_fill_len: assert property (p_fill_len) else $error("line burst not 32 bytes");

  property p_single_len;
    @(posedge CLK_IN) disable iff (!RESET_N_IN)
      BUS_REQ_OUT && BUS_CMD_OUT.kind inside {BUS_SRD, BUS_SWR} |-> BUS_CMD_OUT.len inside {[1:8]};
  endproperty
  a_single_len: assert property (p_single_len) else $error("single cycle length out of range");

  property p_no_ken_no_fill;
    @(posedge CLK_IN) disable iff (!RESET_N_IN)
      state_q == ST_DMISS && !req_q.wr && wait_q == `CCC_KEN_WAIT && ken_n_s
        |=> state_q == ST_SRD && BUS_CMD_OUT.kind == BUS_SRD;
  endproperty
  a_no_ken_no_fill: assert property (p_no_ken_no_fill) else $error("fill without cache enable");

  property p_read_hit;
    @(posedge CLK_IN) disable iff (!RESET_N_IN)
      take_core && !CORE_REQ_IN.icache && !CORE_REQ_IN.wr && c_dhit
        |=> CORE_ACK_OUT && CORE_HIT_OUT && !BUS_REQ_OUT && d_st_q[r_idx] == $past(d_st_q[c_idx]);
  endproperty
  a_read_hit: assert property (p_read_hit) else $error("read hit changed state or used bus");

  property p_wr_hit_excl;
    @(posedge CLK_IN) disable iff (!RESET_N_IN)
      take_core && !CORE_REQ_IN.icache && CORE_REQ_IN.wr && c_dhit && d_st_q[c_idx] != MESI_S
        |=> CORE_ACK_OUT && d_st_q[r_idx] == MESI_M;
  endproperty
  a_wr_hit_excl: assert property (p_wr_hit_excl) else $error("write hit did not go modified");

  property p_inquire_hit_modified_n_pair;
    @(posedge CLK_IN) disable iff (!RESET_N_IN)
      $fell(INQUIRE_HIT_MODIFIED_N_OUT) |-> !INQUIRE_HIT_N_OUT && state_q == ST_WB && BUS_CMD_OUT.kind == BUS_BWR;
  endproperty
  a_inquire_hit_modified_n_pair: assert property (p_inquire_hit_modified_n_pair) else $error("hit-modified without hit or writeback");

  property p_page_fault;
    @(posedge CLK_IN) disable iff (!RESET_N_IN)
      page_flush_invalidate_wr && PAGE_FAULT_IN && state_q == ST_IDLE && !inq_pend_q && !flush_pend_q && !page_pend_q
        |=> pf_q ##1 !(state_q == ST_SCAN && !scan_all_q);
  endproperty
  a_page_fault: assert property (p_page_fault) else $error("faulting page operation ran");

  property p_inq_inv;
    @(posedge CLK_IN) disable iff (!RESET_N_IN)
      take_inq && inq_inv_q && q_dhit && d_st_q[q_idx] != MESI_M |=> d_st_q[$past(q_idx)] == MESI_I;
  endproperty
  a_inq_inv: assert property (p_inq_inv) else $error("invalidating inquire left line valid");

  property p_wt_single;
    @(posedge CLK_IN) disable iff (!RESET_N_IN)
      state_q == ST_SWR |-> BUS_CMD_OUT.kind == BUS_SWR;
  endproperty
  a_wt_single: assert property (p_wt_single) else $error("writethrough not a single cycle");
endmodule : ccc_coherency_ctrl

// ===== tb/ccc_bus_model.sv
// Bus unit model that ends each requested bus cycle after a chosen wait.
`timescale 1ns/1ps
module ccc_bus_model import ccc_pkg::*; (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  // Bus cycle port
  input  wire logic       req_in,
  input  wire ccc_bus_s   cmd_in,
  input  wire logic [2:0] wait_in,
  output logic            done_out,
  // Record of finished cycles
  output ccc_bus_s        last_out,
  output logic [7:0]      count_out
);
  logic [2:0] cnt_q;
  // A done pulse is never given twice in a row, so every command ends once.
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      done_out  <= 1'b0;
      cnt_q     <= 3'h0;
      count_out <= 8'h00;
    end else if (done_out || !req_in) begin
      done_out <= 1'b0;
      cnt_q    <= 3'h0;
    end else if (cnt_q >= wait_in) begin
      done_out  <= 1'b1;
      last_out  <= cmd_in;
      count_out <= count_out + 8'h01;
    end else begin
      cnt_q <= cnt_q + 3'h1;
    end
  end
endmodule : ccc_bus_model

// ===== tb/tb_top.sv
// Self-checking bench for the L1 coherency controller.
`timescale 1ns/1ps
`include "ccc_consts.svh"
module tb_top import ccc_pkg::*;;
  localparam logic [31:0] ADR_A = 32'h00012340;
  localparam logic [31:0] ADR_E = 32'h30000060;
  logic        clk, rst_n, valid, ack, hit, breq, bdone, lfr_n, ken_n, wbsel;
  logic        external_address_strobe_n, inv, flush_n, hit_n, inquire_hit_modified_n_n, mwr, mrd, pf;
  logic [31:5] iaddr;
  logic [31:0] maddr;
  logic [63:0] mwd, mrdata, wd;
  logic [2:0]  bwait;
  logic [7:0]  bcnt, c0;
  logic [15:0] rnd;
  ccc_req_s    req;
  ccc_bus_s    bcmd, blast;
  int          err_count, checks;
  int          lfr_cnt, l0;
  ccc_coherency_ctrl dut_u (
    .CLK_IN(clk), .RESET_N_IN(rst_n), .CORE_VALID_IN(valid), .CORE_REQ_IN(req),
    .CORE_ACK_OUT(ack), .CORE_HIT_OUT(hit), .BUS_REQ_OUT(breq), .BUS_CMD_OUT(bcmd),
    .BUS_DONE_IN(bdone), .LINE_FILL_REQUEST_N_OUT(lfr_n), .CACHE_ENABLE_N_IN(ken_n),
    .WRITEBACK_SELECT_IN(wbsel), .EXTERNAL_ADDRESS_STROBE_N_IN(external_address_strobe_n), .INVALIDATE_REQUEST_IN(inv),
    .CACHE_FLUSH_N_IN(flush_n), .INQUIRE_ADDR_IN(iaddr), .INQUIRE_HIT_N_OUT(hit_n),
    .INQUIRE_HIT_MODIFIED_N_OUT(inquire_hit_modified_n_n), .MODEL_REG_WRITE_IN(mwr), .MODEL_REG_READ_IN(mrd),
    .MODEL_REG_ADDR_IN(maddr), .MODEL_REG_WDATA_IN(mwd), .PAGE_FAULT_IN(pf), .MODEL_REG_RDATA_OUT(mrdata));
  ccc_bus_model bus_u (.clk_in(clk), .reset_n_in(rst_n), .req_in(breq), .cmd_in(bcmd),
    .wait_in(bwait), .done_out(bdone), .last_out(blast), .count_out(bcnt));
  // Counts the cycles in which a line fill is requested.
  always @(negedge clk) begin
    if (!lfr_n) lfr_cnt <= lfr_cnt + 1;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr
  function automatic logic [63:0] exp_reg(input logic [63:0] w, input logic f);
    return {32'h0, w[31:12], 10'h0, w[1], f};
  endfunction : exp_reg
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic bchk(input string nm, input logic [7:0] n, input ccc_kind_e k, input logic [5:0] l);
    chk(nm, {bcnt - c0, blast.kind, blast.len}, {n, k, l});
  endtask : bchk
  task automatic give_up;
    err_count++;
    end_sim();
  endtask : give_up
  task automatic core(input logic w, input logic ic, input logic wa, input logic pw, input logic [31:0] a);
    int i;
    @(negedge clk);
    rnd = lfsr(rnd);
    bwait = rnd[2:0];
    c0 = bcnt;
    l0 = lfr_cnt;
    req = '{w, ic, a, 4'h1 + rnd[5:3], pw, wa};
    valid = 1'b1;
    for (i = 0; i < 300 && ack !== 1'b1; i++) @(negedge clk);
    valid = 1'b0;
    if (i == 300) give_up();
  endtask : core
  // System logic strobes with invalidate and address held steady, then waits for the bus request to drop.
  task automatic inq(input logic [31:0] a, input logic iv);
    int i;
    @(negedge clk);
    iaddr = a[31:5];
    inv = iv;
    external_address_strobe_n = 1'b0;
    repeat (6) @(negedge clk);
    external_address_strobe_n = 1'b1;
    repeat (8) @(negedge clk);
    for (i = 0; i < 300 && breq !== 1'b0; i++) @(negedge clk);
    if (i == 300) give_up();
  endtask : inq
  task automatic reg_io(input logic w, input logic [31:0] a, input logic [63:0] d, input logic f);
    @(negedge clk);
    mwr = w;
    mrd = !w;
    maddr = a;
    mwd = d;
    pf = f;
    @(negedge clk);
    mwr = 1'b0;
    mrd = 1'b0;
  endtask : reg_io
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    {rst_n, valid, mwr, mrd, pf, inv, ken_n} = 7'h00;
    {wbsel, external_address_strobe_n, flush_n} = 3'b111;
    {iaddr, maddr, mwd, bwait, req} = '0;
    rnd = 16'h78ea;
    err_count = 0;
    checks = 0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    chk("reset", {ack, breq, lfr_n, hit_n, inquire_hit_modified_n_n, mrdata}, {5'b00111, 64'h0});
    rnd = lfsr(rnd);
    wd = {4{rnd}};
    reg_io(1'b1, `CCC_PAGE_FLUSH_INVALIDATE_ADDR, wd, 1'b1);
    reg_io(1'b1, `CCC_PAGE_FLUSH_INVALIDATE_ADDR + 32'h4, 64'hffff, 1'b0);
    reg_io(1'b0, `CCC_PAGE_FLUSH_INVALIDATE_ADDR, 64'h0, 1'b0);
    chk("page reg fault", mrdata, exp_reg(wd, 1'b1));
    reg_io(1'b0, `CCC_PAGE_FLUSH_INVALIDATE_ADDR + 32'h4, 64'h0, 1'b0);
    chk("unmapped", mrdata, 64'h0);
    reg_io(1'b1, `CCC_PAGE_FLUSH_INVALIDATE_ADDR, wd, 1'b0);
    reg_io(1'b0, `CCC_PAGE_FLUSH_INVALIDATE_ADDR, 64'h0, 1'b0);
    chk("page reg ok", mrdata, exp_reg(wd, 1'b0));
    repeat (30) @(negedge clk);
    $display("test page register done");
    core(1'b0, 1'b0, 1'b0, 1'b0, ADR_A);
    bchk("fill", 8'h1, BUS_BRD, 6'h20);
    chk("fill req", lfr_cnt - l0, `CCC_KEN_WAIT + 1);
    core(1'b0, 1'b0, 1'b0, 1'b0, ADR_A);
    chk("read hit", {hit, bcnt - c0}, {1'b1, 8'h0});
    inq(ADR_A, 1'b0);
    chk("inq excl", {hit_n, inquire_hit_modified_n_n}, 2'b01);
    core(1'b1, 1'b0, 1'b0, 1'b0, ADR_A);
    bchk("wr shared", 8'h1, BUS_SWR, {2'b00, req.bytes});
    core(1'b1, 1'b0, 1'b0, 1'b0, ADR_A);
    chk("wr excl", {hit, bcnt - c0}, {1'b1, 8'h0});
    c0 = bcnt;
    inq(ADR_A, 1'b1);
    chk("inq mod", {hit_n, inquire_hit_modified_n_n}, 2'b00);
    bchk("inq wb", 8'h1, BUS_BWR, 6'h20);
    inq(ADR_A, 1'b0);
    chk("inq gone", {hit_n, inquire_hit_modified_n_n}, 2'b11);
    $display("test inquire done");
    for (int k = 0; k < 4; k++) begin
      core(1'b1, 1'b0, 1'b0, rnd[9], {16'h4000, rnd});
      bchk("wr miss", 8'h1, BUS_SWR, {2'b00, req.bytes});
      chk("wr no fill req", lfr_cnt - l0, 0);
    end
    ken_n = 1'b1;
    core(1'b0, 1'b0, 1'b0, 1'b0, 32'h50000000);
    bchk("single rd", 8'h1, BUS_SRD, {2'b00, req.bytes});
    core(1'b0, 1'b0, 1'b0, 1'b0, 32'h50000000);
    chk("stays inv", hit, 1'b0);
    ken_n = 1'b0;
    core(1'b1, 1'b0, 1'b1, 1'b1, 32'h10000020);
    bchk("alloc wt", 8'h2, BUS_SWR, {2'b00, req.bytes});
    inq(32'h10000020, 1'b0);
    chk("alloc wt st", {hit_n, inquire_hit_modified_n_n}, 2'b01);
    wbsel = 1'b0;
    core(1'b0, 1'b0, 1'b0, 1'b0, 32'h60000080);
    core(1'b1, 1'b0, 1'b0, 1'b0, 32'h60000080);
    bchk("wt fill", 8'h1, BUS_SWR, {2'b00, req.bytes});
    wbsel = 1'b1;
    core(1'b1, 1'b0, 1'b1, 1'b0, 32'h20000040);
    bchk("alloc wb", 8'h1, BUS_BRD, 6'h20);
    $display("test write done");
    c0 = bcnt;
    flush_n = 1'b0;
    repeat (6) @(negedge clk);
    flush_n = 1'b1;
    repeat (80) @(negedge clk);
    bchk("flush", 8'h1, BUS_BWR, 6'h20);
    inq(32'h10000020, 1'b0);
    chk("flush inv", {hit_n, inquire_hit_modified_n_n}, 2'b11);
    $display("test flush done");
    core(1'b1, 1'b0, 1'b1, 1'b0, ADR_E);
    core(1'b0, 1'b1, 1'b0, 1'b0, ADR_E);
    bchk("ifetch snoop", 8'h2, BUS_BRD, 6'h20);
    core(1'b0, 1'b1, 1'b0, 1'b0, ADR_E);
    chk("ifetch hit", {hit, bcnt - c0}, {1'b1, 8'h0});
    inq(ADR_E, 1'b0);
    chk("ifetch inv", {hit_n, inquire_hit_modified_n_n}, 2'b01);
    ken_n = 1'b1;
    core(1'b0, 1'b0, 1'b0, 1'b0, ADR_E);
    bchk("data snoop", 8'h1, BUS_SRD, {2'b00, req.bytes});
    inq(ADR_E, 1'b0);
    chk("data snoop inv", {hit_n, inquire_hit_modified_n_n}, 2'b11);
    $display("test snoop done");
    for (int k = 0; k < 2; k++) begin
      core(1'b1, 1'b0, 1'b1, 1'b0, ADR_A);
      c0 = bcnt;
      reg_io(1'b1, `CCC_PAGE_FLUSH_INVALIDATE_ADDR, {32'h0, ADR_A[31:12], 10'h0, k[0], 1'b0}, 1'b0);
      repeat (40) @(negedge clk);
      chk("page wb", {bcnt - c0}, {7'h0, !k[0]});
      inq(ADR_A, 1'b0);
      chk("page inv", {hit_n, inquire_hit_modified_n_n}, 2'b11);
    end
    $display("test page operation done");
    end_sim();
  end
endmodule : tb_top
